// file: hdl/tmr_timer.sv
// 16-bit interval timer with clear/set/invert register aliases
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - aliases +4/+8/+C clear, set, invert bits
// - unimplemented bits ignore writes, read zero
// - control bit 15 enables, reset off
// - stop-in-idle halts counting during idle
// - write-block ignores count writes while pending
// - pending flag set during async count write
// - pending flag reads zero when synchronous
// - selector picks oscillator, pin or rc
// - gate only active with internal clock
// - prescale 1, 8, 64 or 256
// - sync bit picks sync or async external mode; both are synchronized alike
// - bit 1 picks internal or external
// - four modes, free-running timer or counter
// - keeps counting in sleep from running source only in async external mode
module tmr_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire tmr_pkg::tmr_ext_s ext_clk_in,
    output logic [31:0] rdata,
    output logic period_match_irq
);
    tmr_pkg::tmr_ctrl_s ctrl_r;
    logic [15:0] count_r;
    logic [15:0] period_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic [1:0] wip_cnt_r;
    logic [15:0] wip_val_r;
    logic wip_r;
    logic [7:0] ps_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic gate_s1_r;
    logic gate_s2_r;
    logic gate_s3_r;
    logic ext_raw;
    logic ext_edge;
    logic src_tick;
    logic cnt_tick;
    logic run;
    logic async_mode;
    logic [15:0] ctrl_bits;
    logic [1:0] alias_sel;
    logic [15:0] reg_base;
    logic sel_ctrl;
    logic sel_count;
    logic sel_period;
    logic count_wr;
    logic count_wr_ok;
    logic [15:0] ctrl_nxt;
    logic [15:0] period_nxt;
    logic [15:0] count_wval;

    function automatic logic [15:0] apply_alias(input logic [1:0] sel,
                                                input logic [15:0] cur,
                                                input logic [15:0] val);
        case (sel)
            tmr_pkg::TMR_ALIAS_CLR: apply_alias = cur & ~val;
            tmr_pkg::TMR_ALIAS_SET: apply_alias = cur | val;
            tmr_pkg::TMR_ALIAS_INV: apply_alias = cur ^ val;
            default: apply_alias = val;
        endcase
    endfunction

    function automatic logic [7:0] ps_limit(input logic [1:0] code);
        case (code)
            2'h1: ps_limit = tmr_pkg::TMR_PS_DIV8;
            2'h2: ps_limit = tmr_pkg::TMR_PS_DIV64;
            2'h3: ps_limit = tmr_pkg::TMR_PS_DIV256;
            default: ps_limit = 8'h00;
        endcase
    endfunction

    assign ctrl_bits = {ctrl_r.on, 1'b0, ctrl_r.stop_in_idle, ctrl_r.async_write_block,
                        wip_r, 1'b0, ctrl_r.ext_clock_select, ctrl_r.gate_accumulate_en,
                        1'b0, ctrl_r.prescale_select, 1'b0, ctrl_r.ext_clock_sync,
                        ctrl_r.clock_source_select, 1'b0};

    // address decode: low nibble picks the alias, rest the register
    assign alias_sel = addr[3:2];
    assign reg_base = {addr[15:4], 4'h0};
    assign sel_ctrl = (reg_base == tmr_pkg::TMR_OFS_CONTROL) && (addr[1:0] == 2'h0);
    assign sel_count = (reg_base == tmr_pkg::TMR_OFS_COUNT) && (addr[1:0] == 2'h0);
    assign sel_period = (reg_base == tmr_pkg::TMR_OFS_PERIOD) && (addr[1:0] == 2'h0);

    assign async_mode = ctrl_r.clock_source_select && !ctrl_r.ext_clock_sync;
    assign count_wr = wr && sel_count;
    // with blocking set, writes during a pending transfer are dropped
    assign count_wr_ok = count_wr && !(wip_r && ctrl_r.async_write_block);
    assign count_wval = apply_alias(alias_sel, count_r, wdata[15:0]);
    // upper halfword and reserved positions never stored
    assign ctrl_nxt = apply_alias(alias_sel, ctrl_bits, wdata[15:0])
                      & tmr_pkg::TMR_CTRL_WMASK;
    assign period_nxt = apply_alias(alias_sel, period_r, wdata[15:0]);

    // external source select
    always_comb begin
        case (ctrl_r.ext_clock_select)
            tmr_pkg::TMR_ECS_SECONDARY_OSC: ext_raw = ext_clk_in.secondary_osc;
            tmr_pkg::TMR_ECS_PIN: ext_raw = ext_clk_in.timer_ext_input_pin;
            tmr_pkg::TMR_ECS_LOW_POWER_RC_OSC: ext_raw = ext_clk_in.low_power_rc_osc;
            default: ext_raw = 1'b0;
        endcase
    end

    // both async and sync external paths are edge-sampled here; the async path
    // differs in that it keeps running in sleep and needs the write handshake
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            gate_s1_r <= 1'b0;
            gate_s2_r <= 1'b0;
            gate_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_raw;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            gate_s1_r <= ext_clk_in.timer_ext_input_pin;
            gate_s2_r <= gate_s1_r;
            gate_s3_r <= gate_s2_r;
        end
    end
    assign ext_edge = ext_s2_r && !ext_s3_r;

    // idle stops only when asked; sleep stops all but the async external mode
    assign run = ctrl_r.on
                 && !(idle_mode && ctrl_r.stop_in_idle)
                 && !(sleep_mode && !async_mode);

    always_comb begin
        if (ctrl_r.clock_source_select) begin
            src_tick = ext_edge;
        end else if (ctrl_r.gate_accumulate_en) begin
            src_tick = gate_s2_r;
        end else begin
            src_tick = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ps_r <= 8'h00;
        end else if (!run) begin
            ps_r <= 8'h00;
        end else if (src_tick) begin
            ps_r <= (ps_r >= ps_limit(ctrl_r.prescale_select)) ? 8'h00 : ps_r + 8'h01;
        end
    end
    assign cnt_tick = run && src_tick && (ps_r >= ps_limit(ctrl_r.prescale_select));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= tmr_pkg::tmr_ctrl_s'(10'h000);
        end else if (wr && sel_ctrl) begin
            ctrl_r.on <= ctrl_nxt[tmr_pkg::TMR_BIT_ON];
            ctrl_r.stop_in_idle <= ctrl_nxt[tmr_pkg::TMR_BIT_STOP_IN_IDLE];
            ctrl_r.async_write_block <= ctrl_nxt[tmr_pkg::TMR_BIT_WDIS];
            ctrl_r.ext_clock_select <= ctrl_nxt[tmr_pkg::TMR_BIT_ECS +: 2];
            ctrl_r.gate_accumulate_en <= ctrl_nxt[tmr_pkg::TMR_BIT_GATE];
            ctrl_r.prescale_select <= ctrl_nxt[tmr_pkg::TMR_BIT_PS +: 2];
            ctrl_r.ext_clock_sync <= ctrl_nxt[tmr_pkg::TMR_BIT_SYNC];
            ctrl_r.clock_source_select <= ctrl_nxt[tmr_pkg::TMR_BIT_CS];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            period_r <= tmr_pkg::TMR_PERIOD_RST;
        end else if (wr && sel_period) begin
            period_r <= period_nxt; // values 0 and 1 are left to software
        end
    end

    // async count writes are held and land after a fixed transfer delay
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wip_r <= 1'b0;
            wip_cnt_r <= 2'h0;
            wip_val_r <= tmr_pkg::TMR_COUNT_RST;
        end else if (count_wr_ok && async_mode) begin
            wip_r <= 1'b1;
            wip_cnt_r <= tmr_pkg::TMR_ASYNC_WR_CYC;
            wip_val_r <= count_wval;
        end else if (!async_mode) begin
            wip_r <= 1'b0;
            wip_cnt_r <= 2'h0;
        end else if (wip_r) begin
            wip_cnt_r <= wip_cnt_r - 2'h1;
            wip_r <= (wip_cnt_r != 2'h1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= tmr_pkg::TMR_COUNT_RST;
        end else if (count_wr_ok && !async_mode) begin
            count_r <= count_wval;
        end else if (wip_r && async_mode && wip_cnt_r == 2'h1) begin
            count_r <= wip_val_r;
        end else if (cnt_tick) begin
            count_r <= (count_r == period_r) ? 16'h0000 : count_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (cnt_tick && count_r == period_r && !ctrl_r.gate_accumulate_en)
                     || (cnt_tick && count_r == period_r && ctrl_r.clock_source_select)
                     || (ctrl_r.on && !ctrl_r.clock_source_select
                         && ctrl_r.gate_accumulate_en && gate_s3_r && !gate_s2_r);
        end
    end
    assign period_match_irq = irq_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h00000000;
        end else if (rd && sel_ctrl) begin
            rdata_r <= {16'h0000, ctrl_bits};
        end else if (rd && sel_count) begin
            rdata_r <= {16'h0000, count_r};
        end else if (rd && sel_period) begin
            rdata_r <= {16'h0000, period_r};
        end else begin
            rdata_r <= 32'h00000000;
        end
    end
    assign rdata = rdata_r;

    AST_OFF_NO_COUNT: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_r.on && !count_wr && !wip_r |=> $stable(count_r))
        else $error("count moved while timer off");
    AST_IDLE_HALT: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.stop_in_idle && idle_mode && !count_wr && !wip_r |=> $stable(count_r))
        else $error("count moved in idle with stop set");
    AST_WIP_SYNC_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        !async_mode |=> !wip_r)
        else $error("pending flag set in sync mode");
    // a rewrite in legacy mode restarts the transfer, so only the hold time is fixed here
    AST_WIP_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        count_wr_ok && async_mode |=> (wip_r || !async_mode) [*3])
        else $error("pending flag timing wrong");
    AST_WIP_LAND: assert property (@(posedge sys_clk) disable iff (!resetn)
        async_mode && wip_r && wip_cnt_r == 2'h1 && !count_wr_ok
        |=> !wip_r && count_r == $past(wip_val_r))
        else $error("pending count write did not land");
    AST_WRITE_BLOCK: assert property (@(posedge sys_clk) disable iff (!resetn)
        wip_r && ctrl_r.async_write_block && count_wr |=> $stable(wip_val_r))
        else $error("blocked count write accepted");
    AST_WRAP: assert property (@(posedge sys_clk) disable iff (!resetn)
        cnt_tick && count_r == period_r && !count_wr && !wip_r |=> count_r == 16'h0000)
        else $error("count did not wrap at period");
    AST_UPPER_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        1'b1 |-> rdata_r[31:16] == 16'h0000)
        else $error("upper halfword not zero");
    AST_PRESCALE: assert property (@(posedge sys_clk) disable iff (!resetn)
        cnt_tick && ctrl_r.prescale_select == 2'h1 && !ctrl_r.clock_source_select
        && !ctrl_r.gate_accumulate_en && ctrl_r.on && !idle_mode && !sleep_mode
        && !(wr && sel_ctrl) |=> !cnt_tick [*7])
        else $error("1:8 prescale ticked early");
    AST_PS_RESTART: assert property (@(posedge sys_clk) disable iff (!resetn)
        cnt_tick |=> ps_r == 8'h00)
        else $error("prescaler not restarted after tick");

    // alias arithmetic, checked on the count register in sync mode
    AST_ALIAS_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
        count_wr_ok && !async_mode && alias_sel == tmr_pkg::TMR_ALIAS_CLR
        |=> count_r == ($past(count_r) & ~$past(wdata[15:0])))
        else $error("clear alias wrong");
    AST_ALIAS_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        count_wr_ok && !async_mode && alias_sel == tmr_pkg::TMR_ALIAS_SET
        |=> count_r == ($past(count_r) | $past(wdata[15:0])))
        else $error("set alias wrong");
    AST_ALIAS_INV: assert property (@(posedge sys_clk) disable iff (!resetn)
        count_wr_ok && !async_mode && alias_sel == tmr_pkg::TMR_ALIAS_INV
        |=> count_r == ($past(count_r) ^ $past(wdata[15:0])))
        else $error("invert alias wrong");

    // reserved positions and unmapped reads
    AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd && !sel_ctrl && !sel_count && !sel_period |=> rdata_r == 32'h00000000)
        else $error("unmapped read not zero");
    AST_CTRL_RESERVED: assert property (@(posedge sys_clk) disable iff (!resetn)
        1'b1 |-> (ctrl_bits & ~(tmr_pkg::TMR_CTRL_WMASK | 16'h0800)) == 16'h0000)
        else $error("reserved control bit set");

    // count step, match pulse and running in idle without the stop bit
    AST_TICK_STEP: assert property (@(posedge sys_clk) disable iff (!resetn)
        cnt_tick && count_r != period_r && !count_wr && !wip_r
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("count did not step on tick");
    AST_IRQ_PULSE: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_match_irq && period_r > 16'h0001 |=> !period_match_irq)
        else $error("match pulse longer than one cycle");
    AST_IDLE_RUN: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.on && !ctrl_r.stop_in_idle && idle_mode && !sleep_mode |-> run)
        else $error("timer halted in idle without stop bit");

    // source selection
    AST_ECS_RESERVED: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.ext_clock_select == 2'h3 |-> ext_raw == 1'b0)
        else $error("reserved selector passed a clock");
    AST_EXT_SOURCE: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.clock_source_select |-> src_tick == ext_edge)
        else $error("gate affected external counting");
    AST_INTERNAL_TICK: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_r.clock_source_select && !ctrl_r.gate_accumulate_en |-> src_tick)
        else $error("internal source not ticking");

    // gated accumulation
    AST_GATE_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.on && !ctrl_r.clock_source_select && ctrl_r.gate_accumulate_en
        && !gate_s2_r |-> !cnt_tick)
        else $error("count advanced with gate low");
    AST_GATE_FALL: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_r.on && !ctrl_r.clock_source_select && ctrl_r.gate_accumulate_en
        && gate_s3_r && !gate_s2_r |=> period_match_irq)
        else $error("no pulse on gate fall");

    // sleep: only the async external path keeps running
    AST_SLEEP_SYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
        sleep_mode && !async_mode |-> !cnt_tick)
        else $error("sync timer counted in sleep");
    AST_SLEEP_ASYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
        sleep_mode && async_mode && ctrl_r.on && !idle_mode |-> run)
        else $error("async timer halted in sleep");
endmodule

// file: hdl/tmr_pkg.sv
// package for the 16-bit interval timer: register map, fields, reset values
package tmr_pkg;
    localparam logic [15:0] TMR_OFS_CONTROL = 16'h8000;
    localparam logic [15:0] TMR_OFS_COUNT = 16'h8010;
    localparam logic [15:0] TMR_OFS_PERIOD = 16'h8020;
    localparam logic [1:0] TMR_ALIAS_WRITE = 2'h0;
    localparam logic [1:0] TMR_ALIAS_CLR = 2'h1;
    localparam logic [1:0] TMR_ALIAS_SET = 2'h2;
    localparam logic [1:0] TMR_ALIAS_INV = 2'h3;
    localparam int TMR_BIT_ON = 15;
    localparam int TMR_BIT_STOP_IN_IDLE = 13;
    localparam int TMR_BIT_WDIS = 12;
    localparam int TMR_BIT_WIP = 11;
    localparam int TMR_BIT_ECS = 8;
    localparam int TMR_BIT_GATE = 7;
    localparam int TMR_BIT_PS = 4;
    localparam int TMR_BIT_SYNC = 2;
    localparam int TMR_BIT_CS = 1;
    // writable control bits: 15,13,12,9,8,7,5,4,2,1
    localparam logic [15:0] TMR_CTRL_WMASK = 16'hB3B6;
    localparam logic [15:0] TMR_CTRL_RST = 16'h0000;
    localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
    localparam logic [15:0] TMR_PERIOD_RST = 16'hFFFF;
    localparam logic [1:0] TMR_ECS_SECONDARY_OSC = 2'h0;
    localparam logic [1:0] TMR_ECS_PIN = 2'h1;
    localparam logic [1:0] TMR_ECS_LOW_POWER_RC_OSC = 2'h2;
    localparam logic [7:0] TMR_PS_DIV8 = 8'h07;
    localparam logic [7:0] TMR_PS_DIV64 = 8'h3F;
    localparam logic [7:0] TMR_PS_DIV256 = 8'hFF;
    // cycles a count write takes to land in the async domain
    localparam logic [1:0] TMR_ASYNC_WR_CYC = 2'h3;

    typedef struct packed {
        logic on;
        logic stop_in_idle;
        logic async_write_block;
        logic [1:0] ext_clock_select;
        logic gate_accumulate_en;
        logic [1:0] prescale_select;
        logic ext_clock_sync;
        logic clock_source_select;
    } tmr_ctrl_s;

    typedef struct packed {
        logic secondary_osc;
        logic timer_ext_input_pin;
        logic low_power_rc_osc;
    } tmr_ext_s;
endpackage

// file: verification/tmr_timer_tb.sv
// self-checking bench for the 16-bit interval timer
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] CT = tmr_pkg::TMR_OFS_CONTROL;
    localparam logic [15:0] CN = tmr_pkg::TMR_OFS_COUNT;
    localparam logic [15:0] PR = tmr_pkg::TMR_OFS_PERIOD;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle_mode = 1'b0;
    logic sleep_mode = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] ctl;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] d;
    logic period_match_irq;
    tmr_pkg::tmr_ext_s ext_clk_in = '0;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int c;
    int divs[4] = '{1, 8, 64, 256};

    tmr_timer DUT (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ext_clk_in(ext_clk_in),
        .rdata(rdata), .period_match_irq(period_match_irq));

    always #10 sys_clk = ~sys_clk;

    // generous ceiling: the slowest prescale pass alone needs about 11k cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    // strobes stay up between back-to-back calls; tick lowers them
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic tick(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string m);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk) d = rdata;
        @(posedge sys_clk);
        chk(d, exp, m);
    endtask

    task automatic cnt_irq(input int n);
        tick(0);
        c = 0;
        repeat (n) @(negedge sys_clk) if (period_match_irq === 1'b1) c++;
        @(posedge sys_clk);
    endtask

    task automatic wait_irq(input int lim);
        tick(0);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (period_match_irq !== 1'b1 && c < lim);
        @(posedge sys_clk);
        chk(32'(c < lim), 32'h1, "irq missing");
    endtask

    task automatic setup(input logic [15:0] cv, input logic [15:0] per);
        wr_reg(CT, 32'h0);
        wr_reg(CN, 32'h0);
        wr_reg(PR, {16'h0000, per}); // callers never pass 0 or 1
        wr_reg(CT, {16'h0000, cv});
        tick(1);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd_chk(CT, 32'h0, "ctrl reset");
        rd_chk(CN, 32'h0, "count reset");
        rd_chk(PR, 32'hFFFF, "period reset");
        wr_reg(PR, 32'hFFFF_0005);
        wr_reg(CT, 32'hFFFF_FFFF);
        rd_chk(PR, 32'h5, "period upper");
        rd_chk(CT, {16'h0000, tmr_pkg::TMR_CTRL_WMASK}, "ctrl mask");
        wr_reg(CT + 16'h4, 32'hFFFF);
        rd_chk(CT, 32'h0, "ctrl clr");
        wr_reg(CT + 16'h8, 32'h0030);
        wr_reg(CT + 16'hC, 32'h0019);
        rd_chk(CT, 32'h0020, "ctrl set inv");
        wr_reg(CN, 32'h00F0);
        wr_reg(CN + 16'h8, 32'h000F);
        wr_reg(CN + 16'h4, 32'h00F0);
        wr_reg(CN + 16'hC, 32'h00FF);
        wr_reg(16'h8030, 32'hFFFF);
        rd_chk(CN, 32'h00F0, "count aliases");
        rd_chk(16'h8030, 32'h0, "unmapped read");
        rd_chk(CT, 32'h0020, "unmapped write");
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            setup(16'h8000 | (16'(p) << 4), 16'h0003);
            wait_irq(2000);
            cnt_irq(40 * divs[p]);
            chk(32'(c), 32'd10, "prescale irq count");
        end
        $display("test prescale done");
        idle_mode <= 1'b1;
        setup(16'hA000, 16'h0003);
        cnt_irq(100);
        chk(32'(c), 32'd0, "idle stop");
        idle_mode <= 1'b0;
        wait_irq(20);
        cnt_irq(40);
        chk(32'(c), 32'd10, "idle resume");
        idle_mode <= 1'b1;
        setup(16'h8000, 16'h0003);
        wait_irq(20);
        cnt_irq(40);
        chk(32'(c), 32'd10, "idle run");
        idle_mode <= 1'b0;
        setup(16'h0000, 16'h0003);
        cnt_irq(100);
        chk(32'(c), 32'd0, "timer off");
        $display("test idle done");
        // gated accumulation from the pin; gated mode gives no match pulses, only the gate fall raises one
        setup(16'h8080, 16'hFFFF);
        cnt_irq(20);
        chk(32'(c), 32'd0, "gate idle");
        ext_clk_in <= 3'b010;
        tick(10);
        ext_clk_in <= 3'b000;
        wait_irq(10);
        $display("test gate done");
        for (int s = 0; s < 2; s++) begin
            for (int e = 0; e < 4; e++) begin
                ctl = (s == 0) ? 16'h8186 : 16'h8182;
                ctl[9:8] = e[1:0];
                sleep_mode <= (s == 1);
                setup(ctl, 16'h0003);
                repeat (6) begin
                    ext_clk_in <= tmr_pkg::tmr_ext_s'((e < 3) ? 3'(3'b100 >> e) : 3'b111);
                    tick(4);
                    ext_clk_in <= 3'b000;
                    tick(4);
                end
                tick(6);
                rd_chk(CN, (e < 3) ? 32'd2 : 32'd0, "ext count");
                sleep_mode <= 1'b0;
            end
        end
        $display("test external done");
        setup(16'h8102, 16'hFFFF);
        wr_reg(CN, 32'h1234);
        rd_chk(CT, 32'h8902, "pending set");
        tick(5);
        rd_chk(CT, 32'h8102, "pending clear");
        rd_chk(CN, 32'h1234, "async write");
        wr_reg(CT, 32'h9102);
        wr_reg(CN, 32'h1111);
        wr_reg(CN, 32'h2222);
        tick(6);
        rd_chk(CN, 32'h1111, "blocked write");
        wr_reg(CT, 32'h8102);
        wr_reg(CN, 32'h3333);
        wr_reg(CN, 32'h4444);
        tick(6);
        rd_chk(CN, 32'h4444, "legacy write");
        wr_reg(CT, 32'h8106);
        wr_reg(CN, 32'h0005);
        rd_chk(CT, 32'h8106, "sync pending");
        $display("test async write done");
        stop_test();
    end
endmodule
